// *** common/scid_map.vh ***
// register map, field positions, reset values and timing figures of the input decoder
`ifndef SCID_MAP_VH
`define SCID_MAP_VH

// register byte offsets
`define SCID_CONFIG_OFS       8'h00
`define SCID_GEAR_ONE_OFS     8'h04
`define SCID_GEAR_TWO_OFS     8'h08
`define SCID_STATUS_OFS       8'h0C
`define SCID_DEVIATION_OFS    8'h10

// config fields
`define SCID_CFG_MODE_LSB     0
`define SCID_CFG_ZSW_LSB      2
`define SCID_CFG_FMT_LSB      4
`define SCID_CFG_RESET        6'h00
`define SCID_GEAR_RESET       16'h0001

// control_mode_setting values
`define SCID_MODE_POS_A       2'h0
`define SCID_MODE_SPEED       2'h1
`define SCID_MODE_POS_B       2'h2

// zero_speed_torque_switch_setting values
`define SCID_ZSW_GAIN_ONLY    2'h0
`define SCID_ZSW_ZERO_SPEED   2'h1
`define SCID_ZSW_TORQUE       2'h2

// pulse_format_setting values
`define SCID_FMT_FWD_REV      2'h0
`define SCID_FMT_STEP_DIR     2'h1
`define SCID_FMT_QUAD         2'h2

// status bit positions
`define SCID_ST_SERVO         0
`define SCID_ST_ALM_RES       1
`define SCID_ST_ALM_LATCH     2
`define SCID_ST_GAIN          3
`define SCID_ST_ZERO          4
`define SCID_ST_TORQUE        5
`define SCID_ST_SPD_LSB       6
`define SCID_ST_FWD_OK        8
`define SCID_ST_REV_OK        9
`define SCID_ST_CLEAR         10
`define SCID_ST_GEAR          11

// timing
`define SCID_CLK_KHZ          40000
`define SCID_ALM_RESET_MS     120

`endif

// *** dv/scid_host.sv ***
// host motion controller model driving the command pulse pair
`timescale 1ns/10ps
module scid_host (
  input  wire mclk,
  output reg  pair_one,
  output reg  pair_two
);
  initial begin
    pair_one = 1'b0;
    pair_two = 1'b0;
  end
  // rate limit
  // each level lasts 40 clocks, so one period is 500 kpps at most
  task hold;
    repeat (40) @(posedge mclk);
  endtask
  task send(input [1:0] fmt, input fwd);
    case (fmt)
      2'h0: begin
        if (fwd) begin
          pair_two <= 1'b1; hold; pair_two <= 1'b0; hold;
        end else begin
          pair_one <= 1'b1; hold; pair_one <= 1'b0; hold;
        end
      end
      2'h1: begin
        pair_two <= fwd; hold; pair_one <= 1'b1; hold; pair_one <= 1'b0; hold;
      end
      default: begin
        if (fwd) begin
          pair_one <= 1'b1; hold; pair_two <= 1'b1; hold;
          pair_one <= 1'b0; hold; pair_two <= 1'b0; hold;
        end else begin
          pair_two <= 1'b1; hold; pair_one <= 1'b1; hold;
          pair_two <= 1'b0; hold; pair_one <= 1'b0; hold;
        end
      end
    endcase
  endtask
endmodule // scid_host

// *** dv/scid_input_decoder_bench.sv ***
// self-checking bench for the input decoder
`timescale 1ns/10ps
`include "scid_map.vh"
module scid_input_decoder_bench;
  reg mclk = 0, reset = 1, cyc = 0, stb = 0, we = 0, run = 0, arst = 0, clr = 0;
  reg p5 = 0, p6 = 0, rlim = 0, flim = 0, ra = 0, la = 0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] dat = 32'h0, q, d0;
  wire [31:0] rd, dev;
  wire [15:0] gear;
  wire        ack, servo, gain, zero, torq, s1, s2, fp, rp, cs, cf, p1, p2;
  integer bad_count = 0, checks = 0;
  always #12.5 mclk = ~mclk;
  scid_host u_host (.mclk(mclk), .pair_one(p1), .pair_two(p2));
  scid_input_decoder #(.ALM_RESET_CYC(20)) u_dut (.mclk(mclk), .reset(reset), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(rd), .wb_ack_o(ack), .run_input(run), .alarm_reset_input(arst),
    .deviation_clear_input(clr), .shared_pin5_input(p5), .shared_pin6_input(p6),
    .reverse_limit_input(rlim), .forward_limit_input(flim), .pulse_pair_one_input(p1),
    .pulse_pair_two_input(p2), .resettable_alarm_event(ra), .latched_alarm_event(la),
    .feedback_step(1'b0), .feedback_dir(1'b0), .servo_enable(servo), .gain_switch_input(gain),
    .zero_speed_input(zero), .torque_limit_set_select(torq), .speed_select_bit_one(s1),
    .speed_select_bit_two(s2), .gear_numerator_active(gear), .forward_permit(fp),
    .reverse_permit(rp), .command_step(cs), .command_forward(cf), .deviation_count(dev));
  task final_report;
    if (bad_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task chkb(input string n, input e, input g);
    chk(n, {31'h0, e}, {31'h0, g});
  endtask
  // hold the request until ack is sampled high, bounded
  task wb(input w, input [7:0] a, input [31:0] d);
    integer i;
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
    i = 0;
    do begin @(posedge mclk); i++; end while (ack !== 1'b1 && i < 50);
    q = rd;
    cyc <= 0; stb <= 0;
    if (i >= 50) begin bad_count++; final_report; end
  endtask
  task cfg(input [1:0] m, input [1:0] z, input [1:0] f);
    wb(1, `SCID_CONFIG_OFS, {26'h0, f, z, m});
  endtask
  task settle;
    repeat (6) @(posedge mclk);
  endtask
  task t_regs;
    wb(0, `SCID_CONFIG_OFS, 0); chk("config", 32'h0, q);
    wb(0, `SCID_GEAR_ONE_OFS, 0); chk("gear one", 32'h1, q);
    wb(1, 8'h14, 32'hFFFF); wb(0, 8'h14, 0); chk("unmapped", 32'h0, q);
  endtask
  task t_run;
    run <= 1; settle; chkb("servo on", 1, servo);
    run <= 0; settle; chkb("servo off", 0, servo);
  endtask
  task t_limits;
    integer i;
    for (i = 0; i < 4; i++) begin
      flim <= i[0]; rlim <= i[1]; settle;
      chkb("fwd permit", i[0], fp);
      chkb("rev permit", i[1], rp);
    end
    flim <= 0; rlim <= 0; settle;
    chkb("fwd prohibit", 0, fp);
    chkb("rev prohibit", 0, rp);
  endtask
  task t_pulses;
    integer f;
    for (f = 0; f < 3; f++) begin
      cfg(0, 0, f[1:0]); wb(0, `SCID_DEVIATION_OFS, 0); d0 = q;
      u_host.send(f[1:0], 1); settle; wb(0, `SCID_DEVIATION_OFS, 0);
      chk("dev fwd", d0 + (f == 2 ? 32'h4 : 32'h1), q);
      u_host.send(f[1:0], 0); settle; wb(0, `SCID_DEVIATION_OFS, 0);
      chk("dev rev", d0, q);
    end
  endtask
  // clear held only briefly to keep the run short
  task t_clear;
    cfg(2, 0, 0); wb(0, `SCID_DEVIATION_OFS, 0); d0 = q;
    u_host.send(0, 1); settle; wb(0, `SCID_DEVIATION_OFS, 0);
    chk("dev counted", d0 + 32'h1, q);
    clr <= 1; settle; u_host.send(0, 1); settle;
    wb(0, `SCID_DEVIATION_OFS, 0); chk("dev cleared", 32'h0, q);
    wb(0, `SCID_STATUS_OFS, 0); chkb("clear flag", 1, q[`SCID_ST_CLEAR]);
    cfg(1, 0, 0); p6 <= 1; settle;
    chkb("speed bit two", 1, s2);
    chkb("speed bit one", 1, s1);
    clr <= 0; p6 <= 0; settle; chkb("speed bit two off", 0, s2);
  endtask
  task p5row(input [1:0] m, input [1:0] z, input v, input [1:0] s, input e);
    cfg(m, z, 0); p5 <= v; settle;
    chkb("pin5 use", e, s == 0 ? gain : (s == 1 ? zero : torq));
  endtask
  task t_pin5;
    p5row(0, 0, 1, 0, 1);
    p5row(2, 1, 0, 0, 0);
    p5row(1, 1, 0, 1, 1);
    p5row(1, 1, 1, 1, 0);
    p5row(1, 0, 0, 1, 0);
    p5row(0, 2, 0, 2, 0);
    p5row(1, 2, 1, 2, 1);
  endtask
  task t_gear;
    wb(1, `SCID_GEAR_ONE_OFS, 32'h5); wb(1, `SCID_GEAR_TWO_OFS, 32'h9); cfg(0, 0, 0);
    p6 <= 0; settle; chk("gear low", 32'h5, {16'h0, gear});
    p6 <= 1; settle; chk("gear high", 32'h9, {16'h0, gear});
    p6 <= 0;
  endtask
  task t_alarm;
    run <= 1; ra <= 1; @(posedge mclk); ra <= 0; settle;
    wb(0, `SCID_STATUS_OFS, 0); chkb("alarm set", 1, q[`SCID_ST_ALM_RES]);
    chkb("servo held off", 0, servo);
    arst <= 1; repeat (10) @(posedge mclk); arst <= 0; settle;
    wb(0, `SCID_STATUS_OFS, 0); chkb("alarm short hold", 1, q[`SCID_ST_ALM_RES]);
    arst <= 1; repeat (25) @(posedge mclk); arst <= 0; settle;
    wb(0, `SCID_STATUS_OFS, 0); chkb("alarm cleared", 0, q[`SCID_ST_ALM_RES]);
    chkb("servo back", 1, servo);
    la <= 1; @(posedge mclk); la <= 0; arst <= 1; repeat (25) @(posedge mclk); arst <= 0; settle;
    wb(0, `SCID_STATUS_OFS, 0); chkb("latched stays", 1, q[`SCID_ST_ALM_LATCH]);
    chkb("servo latched off", 0, servo);
    run <= 0; settle;
    // a mid-run reset is the only way out of a latched alarm
    reset <= 1; @(posedge mclk); reset <= 0; settle;
    wb(0, `SCID_STATUS_OFS, 0); chkb("latch after reset", 0, q[`SCID_ST_ALM_LATCH]);
    chk("gear after reset", 32'h1, {16'h0, gear});
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 0;
    t_regs; t_run; t_limits; t_pulses; t_clear; t_pin5; t_gear; t_alarm;
    final_report;
  end
endmodule // scid_input_decoder_bench

// *** dv/scid_input_decoder_chk.sv ***
// concurrent checks on the input decoder ports
`timescale 1ns/10ps
module scid_input_decoder_chk #(
  parameter DEV_W = 32
) (
  input wire             mclk,
  input wire             reset,
  input wire             wb_cyc_i,
  input wire             wb_stb_i,
  input wire             wb_ack_o,
  input wire             run_input,
  input wire             reverse_limit_input,
  input wire             forward_limit_input,
  input wire             pulse_pair_one_input,
  input wire             pulse_pair_two_input,
  input wire             servo_enable,
  input wire             forward_permit,
  input wire             reverse_permit,
  input wire             command_step,
  input wire             command_forward,
  input wire [DEV_W-1:0] deviation_count
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  reg [3:0] age_reg;
  reg       p1_reg;
  reg       p2_reg;
  // cycles since a pulse pin last moved, saturating
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      age_reg <= 4'hF;
      p1_reg  <= 1'b0;
      p2_reg  <= 1'b0;
    end else begin
      p1_reg <= pulse_pair_one_input;
      p2_reg <= pulse_pair_two_input;
      if (p1_reg != pulse_pair_one_input || p2_reg != pulse_pair_two_input) age_reg <= 4'h0;
      else if (age_reg != 4'hF) age_reg <= age_reg + 4'h1;
    end
  end
  chk_servo_drop_off:
    assert property ($fell(run_input) |-> ##[1:4] !servo_enable) else $error("servo stayed on");
  chk_forward_prohibit:
    assert property ($fell(forward_limit_input) |-> ##[1:4] !forward_permit)
      else $error("forward permit stayed");
  chk_reverse_prohibit:
    assert property ($fell(reverse_limit_input) |-> ##[1:4] !reverse_permit)
      else $error("reverse permit stayed");
  chk_step_one_cycle:
    assert property (command_step |=> !command_step) else $error("step longer than one cycle");
  chk_step_counts_dev:
    assert property (command_step |-> (deviation_count - $past(deviation_count)) ==
      (command_forward ? {{(DEV_W-1){1'b0}}, 1'b1} : {DEV_W{1'b1}}))
      else $error("deviation not stepped by one");
  chk_step_has_cause:
    assert property (command_step |-> age_reg <= 4'h6) else $error("step without pin edge");
  chk_ack_one_cycle:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_latency:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  cover property (command_step && command_forward);
  cover property (command_step && !command_forward);
  cover property ($fell(servo_enable));
endmodule // scid_input_decoder_chk
bind scid_input_decoder scid_input_decoder_chk #(.DEV_W(DEV_W)) u_chk (
  .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .run_input(run_input), .reverse_limit_input(reverse_limit_input),
  .forward_limit_input(forward_limit_input), .pulse_pair_one_input(pulse_pair_one_input),
  .pulse_pair_two_input(pulse_pair_two_input), .servo_enable(servo_enable),
  .forward_permit(forward_permit), .reverse_permit(reverse_permit),
  .command_step(command_step), .command_forward(command_forward),
  .deviation_count(deviation_count));

// *** rtl/scid_input_decoder.v ***
// control connector sequence and command pulse input decoder with wishbone registers
`timescale 1ns/10ps
`include "scid_map.vh"

// Function
// RQ1 - run input high enables motor power; low removes it
// RQ2 - alarm reset held 120 ms clears resettable alarm; latched alarms remain
// RQ3 - position mode: clear pin blocks command pulses and clears deviation counter
// RQ4 - speed mode: clear pin becomes internal speed select bit two
// RQ5 - position mode with setting 0 or 1: pin 5 selects gain set
// RQ6 - speed mode, setting 1: pin 5 low forces zero speed; setting 0 ignores
// RQ7 - setting 2, any mode: pin 5 low torque set one, high set two
// RQ8 - position mode: pin 6 low numerator one, high numerator two
// RQ9 - host sends no pulses 10 ms around a gear switch change
// RQ10 - speed mode: pin 6 becomes internal speed select bit one
// RQ11 - reverse rotation permitted only while reverse limit input high
// RQ12 - forward rotation permitted only while forward limit input high
// RQ13 - pulse pair decoded as forward/reverse, step/direction or quadrature
// RQ14 - counting keeps up with 500 kpps line-driver, 200 kpps open-collector
// RQ15 - every sequence and pulse input synchronised before decoding
module scid_input_decoder #(
  parameter GEAR_W        = 16,
  parameter DEV_W         = 32,
  parameter ALM_RESET_CYC = `SCID_ALM_RESET_MS * `SCID_CLK_KHZ
) (
  input  wire              mclk,
  input  wire              reset,
  input  wire              wb_cyc_i,
  input  wire              wb_stb_i,
  input  wire              wb_we_i,
  input  wire [7:0]        wb_adr_i,
  input  wire [3:0]        wb_sel_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  output reg               wb_ack_o,
  input  wire              run_input,
  input  wire              alarm_reset_input,
  input  wire              deviation_clear_input,
  input  wire              shared_pin5_input,
  input  wire              shared_pin6_input,
  input  wire              reverse_limit_input,
  input  wire              forward_limit_input,
  input  wire              pulse_pair_one_input,
  input  wire              pulse_pair_two_input,
  input  wire              resettable_alarm_event,
  input  wire              latched_alarm_event,
  input  wire              feedback_step,
  input  wire              feedback_dir,
  output reg               servo_enable,
  output reg               gain_switch_input,
  output reg               zero_speed_input,
  output reg               torque_limit_set_select,
  output reg               speed_select_bit_one,
  output reg               speed_select_bit_two,
  output reg  [GEAR_W-1:0] gear_numerator_active,
  output reg               forward_permit,
  output reg               reverse_permit,
  output reg               command_step,
  output reg               command_forward,
  output reg  [DEV_W-1:0]  deviation_count
);

  localparam NSYNC = 11;

  // ---------------- input synchronisers ----------------
  wire [NSYNC-1:0] raw_in = {feedback_dir, feedback_step, latched_alarm_event,
                             resettable_alarm_event, pulse_pair_two_input,
                             pulse_pair_one_input, forward_limit_input,
                             reverse_limit_input, shared_pin6_input,
                             shared_pin5_input, deviation_clear_input};
  reg  [NSYNC-1:0] sync_a_reg;
  reg  [NSYNC-1:0] sync_b_reg;
  reg              run_a_reg;
  reg              run_b_reg;
  reg              arst_a_reg;
  reg              arst_b_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      // RQ15 two-flop synchroniser
      always @(posedge mclk or posedge reset) begin
        if (reset) begin
          sync_a_reg[gi] <= 1'b0;
          sync_b_reg[gi] <= 1'b0;
        end else begin
          sync_a_reg[gi] <= raw_in[gi];
          sync_b_reg[gi] <= sync_a_reg[gi];
        end
      end
    end
  endgenerate

  // RQ15 run and alarm reset synchronisers
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      run_a_reg  <= 1'b0;
      run_b_reg  <= 1'b0;
      arst_a_reg <= 1'b0;
      arst_b_reg <= 1'b0;
    end else begin
      run_a_reg  <= run_input;
      run_b_reg  <= run_a_reg;
      arst_a_reg <= alarm_reset_input;
      arst_b_reg <= arst_a_reg;
    end
  end

  wire clr_s  = sync_b_reg[0];
  wire pin5_s = sync_b_reg[1];
  wire pin6_s = sync_b_reg[2];
  wire rev_s  = sync_b_reg[3];
  wire fwd_s  = sync_b_reg[4];
  wire pa_s   = sync_b_reg[5];
  wire pb_s   = sync_b_reg[6];
  wire ralm_s = sync_b_reg[7];
  wire lalm_s = sync_b_reg[8];
  wire fbs_s  = sync_b_reg[9];
  wire fbd_s  = sync_b_reg[10];

  // ---------------- registers ----------------
  reg  [5:0]        config_reg;
  reg  [GEAR_W-1:0] gear_one_reg;
  reg  [GEAR_W-1:0] gear_two_reg;
  wire [1:0]        mode    = config_reg[`SCID_CFG_MODE_LSB +: 2];
  wire [1:0]        zsw     = config_reg[`SCID_CFG_ZSW_LSB +: 2];
  wire [1:0]        fmt     = config_reg[`SCID_CFG_FMT_LSB +: 2];
  wire              pos_mode = (mode == `SCID_MODE_POS_A) || (mode == `SCID_MODE_POS_B);
  wire              spd_mode = (mode == `SCID_MODE_SPEED);

  wire       wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // writes land at the edge where the master sees ack, as classic cycles expect
  wire       wb_wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  wire [31:0] gear_wdat = {{(32-GEAR_W){1'b0}}, {GEAR_W{1'b0}}} | wb_dat_i;

  // byte enables honoured on the low lanes that hold data
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      config_reg   <= `SCID_CFG_RESET;
      gear_one_reg <= `SCID_GEAR_RESET;
      gear_two_reg <= `SCID_GEAR_RESET;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `SCID_CONFIG_OFS: begin
          if (wb_sel_i[0])
            config_reg <= wb_dat_i[5:0];
        end
        `SCID_GEAR_ONE_OFS: begin
          if (wb_sel_i[0])
            gear_one_reg[7:0] <= gear_wdat[7:0];
          if (wb_sel_i[1])
            gear_one_reg[GEAR_W-1:8] <= gear_wdat[GEAR_W-1:8];
        end
        `SCID_GEAR_TWO_OFS: begin
          if (wb_sel_i[0])
            gear_two_reg[7:0] <= gear_wdat[7:0];
          if (wb_sel_i[1])
            gear_two_reg[GEAR_W-1:8] <= gear_wdat[GEAR_W-1:8];
        end
        default: begin
        end
      endcase
    end
  end

  // ---------------- alarm handling ----------------
  reg        alarm_res_reg;
  reg        alarm_latch_reg;
  reg [31:0] arst_cnt_reg;
  wire       arst_done = (arst_cnt_reg >= ALM_RESET_CYC - 1);

  // RQ2 hold count on the reset input
  always @(posedge mclk or posedge reset) begin
    if (reset)
      arst_cnt_reg <= 32'h00000000;
    else if (!arst_b_reg)
      arst_cnt_reg <= 32'h00000000;
    else if (!arst_done)
      arst_cnt_reg <= arst_cnt_reg + 32'h00000001;
  end

  // RQ2 clear resettable alarm; a new event wins over the clear
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      alarm_res_reg   <= 1'b0;
      alarm_latch_reg <= 1'b0;
    end else begin
      if (ralm_s)
        alarm_res_reg <= 1'b1;
      else if (arst_b_reg && arst_done)
        alarm_res_reg <= 1'b0;
      if (lalm_s)
        alarm_latch_reg <= 1'b1;
    end
  end

  // ---------------- mode-dependent pin meanings ----------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      servo_enable            <= 1'b0;
      gain_switch_input       <= 1'b0;
      zero_speed_input        <= 1'b0;
      torque_limit_set_select <= 1'b0;
      speed_select_bit_one    <= 1'b0;
      speed_select_bit_two    <= 1'b0;
      gear_numerator_active   <= `SCID_GEAR_RESET;
      forward_permit          <= 1'b0;
      reverse_permit          <= 1'b0;
    end else begin
      // RQ1 servo on follows run; an alarm also removes power
      servo_enable <= run_b_reg && !alarm_res_reg && !alarm_latch_reg;
      // RQ5 gain switch selection
      gain_switch_input <= pos_mode && (zsw != `SCID_ZSW_TORQUE) && pin5_s;
      // RQ6 zero speed when pin 5 low
      zero_speed_input <= spd_mode && (zsw == `SCID_ZSW_ZERO_SPEED) && !pin5_s;
      // RQ7 torque limit set choice
      torque_limit_set_select <= (zsw == `SCID_ZSW_TORQUE) && pin5_s;
      // RQ10 pin 6 as speed bit one
      speed_select_bit_one <= spd_mode && pin6_s;
      // RQ4 clear pin as speed bit two
      speed_select_bit_two <= spd_mode && clr_s;
      // RQ8 gear numerator selection; held while in speed mode
      if (pos_mode)
        gear_numerator_active <= pin6_s ? gear_two_reg : gear_one_reg;
      // RQ12 forward overtravel
      forward_permit <= fwd_s;
      // RQ11 reverse overtravel
      reverse_permit <= rev_s;
    end
  end

  // ---------------- command pulse decoding ----------------
  reg        pa_d_reg;
  reg        pb_d_reg;
  reg        step_next;
  reg        fwd_next;
  wire       pa_rise = pa_s && !pa_d_reg;
  wire       pb_rise = pb_s && !pb_d_reg;
  wire       pa_chg  = pa_s ^ pa_d_reg;
  wire       pb_chg  = pb_s ^ pb_d_reg;

  // RQ13 three pulse formats; quadrature counts every edge
  always @* begin
    step_next = 1'b0;
    fwd_next  = 1'b0;
    case (fmt)
      `SCID_FMT_FWD_REV: begin
        step_next = pa_rise ^ pb_rise;
        fwd_next  = pb_rise;
      end
      `SCID_FMT_STEP_DIR: begin
        step_next = pa_rise;
        fwd_next  = pb_s;
      end
      `SCID_FMT_QUAD: begin
        step_next = pa_chg ^ pb_chg;
        fwd_next  = pa_chg ? (pa_s ^ pb_s) : !(pa_s ^ pb_s);
      end
      default: begin
        step_next = 1'b0;
        fwd_next  = 1'b0;
      end
    endcase
  end

  wire clr_active = pos_mode && clr_s;
  wire cmd_take   = step_next && pos_mode && !clr_active;

  // RQ14 one decision per clock leaves a wide margin at top pulse rates
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pa_d_reg        <= 1'b0;
      pb_d_reg        <= 1'b0;
      command_step    <= 1'b0;
      command_forward <= 1'b0;
    end else begin
      pa_d_reg        <= pa_s;
      pb_d_reg        <= pb_s;
      // RQ3 pulses blocked while clearing
      command_step    <= cmd_take;
      if (cmd_take)
        command_forward <= fwd_next;
    end
  end

  // ---------------- deviation counter ----------------
  reg            fbs_d_reg;
  wire           fb_step = fbs_s && !fbs_d_reg;
  reg [DEV_W-1:0] dev_next;
  localparam [DEV_W-1:0] DEV_ONE = {{(DEV_W-1){1'b0}}, 1'b1};

  always @* begin
    dev_next = deviation_count;
    if (cmd_take)
      dev_next = fwd_next ? dev_next + DEV_ONE : dev_next - DEV_ONE;
    if (fb_step)
      dev_next = fbd_s ? dev_next - DEV_ONE : dev_next + DEV_ONE;
  end

  // RQ3 counter cleared while the clear pin is high in position mode
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      fbs_d_reg       <= 1'b0;
      deviation_count <= {DEV_W{1'b0}};
    end else begin
      fbs_d_reg       <= fbs_s;
      if (clr_active)
        deviation_count <= {DEV_W{1'b0}};
      else
        deviation_count <= dev_next;
    end
  end

  // ---------------- wishbone read and answer ----------------
  reg [31:0] status_word;

  always @* begin
    status_word = 32'h00000000;
    status_word[`SCID_ST_SERVO]         = servo_enable;
    status_word[`SCID_ST_ALM_RES]       = alarm_res_reg;
    status_word[`SCID_ST_ALM_LATCH]     = alarm_latch_reg;
    status_word[`SCID_ST_GAIN]          = gain_switch_input;
    status_word[`SCID_ST_ZERO]          = zero_speed_input;
    status_word[`SCID_ST_TORQUE]        = torque_limit_set_select;
    status_word[`SCID_ST_SPD_LSB]       = speed_select_bit_one;
    status_word[`SCID_ST_SPD_LSB + 1]   = speed_select_bit_two;
    status_word[`SCID_ST_FWD_OK]        = forward_permit;
    status_word[`SCID_ST_REV_OK]        = reverse_permit;
    status_word[`SCID_ST_CLEAR]         = clr_active;
    status_word[`SCID_ST_GEAR]          = pos_mode && pin6_s;
  end

  // one wait state: ack one edge after the request, dropped the next
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SCID_CONFIG_OFS:    wb_dat_o <= {26'h0000000, config_reg};
          `SCID_GEAR_ONE_OFS:  wb_dat_o <= {{(32-GEAR_W){1'b0}}, gear_one_reg};
          `SCID_GEAR_TWO_OFS:  wb_dat_o <= {{(32-GEAR_W){1'b0}}, gear_two_reg};
          `SCID_STATUS_OFS:    wb_dat_o <= status_word;
          `SCID_DEVIATION_OFS: wb_dat_o <= deviation_count;
          default:             wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // scid_input_decoder
